// *** coef_bank_a_upper_regs.vh ***
`ifndef COEF_BANK_A_UPPER_REGS_VH
`define COEF_BANK_A_UPPER_REGS_VH

// Register indices; byte address is four times the index
`define IDX_COEF_CENTER_TAP_CHAN_A 13'h0420
`define IDX_COEF_TAP_SIX_CHAN_A 13'h0423
`define IDX_COEF_TAP_SEVEN_CHAN_A 13'h0425
`define IDX_COEF_TAP_EIGHT_CHAN_A 13'h0427

// Register widths
`define CENTER_REG_W 24
`define SIDE_REG_W 16

// Field layout
`define CENTER_FIELD_MSB 17
`define SIDE_FIELD_MSB 11

// Reset values
`define RST_COEF_CENTER_TAP_CHAN_A 24'h000000
`define RST_COEF_TAP_SIDE_CHAN_A 16'h0000

`endif

// *** fir_tap_coeff_bank_a_upper.v ***
// Contract
// R01 - Centre tap register drives tap five of channel A or single filter.
// R02 - Centre tap is 18-bit signed, bits 17:0.
// R03 - Tap six register holds 12-bit signed value in bits 11:0.
// R04 - Tap seven register holds 12-bit signed value in bits 11:0.
// R05 - Tap eight register holds 12-bit signed value in bits 11:0.
// R06 - Readback forces each field MSB to zero; filter sees full value.
// R07 - Coefficients are applied as signed two's complement weights.
// R08 - Centre tap register sits at index 0x420 and resets to zero.
// R09 - Software writes zero to reserved bits and ignores them on read.
`timescale 1ns/1ps
`include "coef_bank_a_upper_regs.vh"

module fir_tap_coeff_bank_a_upper #(
  parameter ADDR_W = 15
) (
  // Clock, reset, enable
  input wire sys_clk_in,
  input wire rst_in,
  input wire clk_en_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output wire pready_out,
  output reg pslverr_out,
  // Coefficients to the equalization filter, full written values
  output wire signed [17:0] coef_tap_five_out,
  output wire signed [11:0] coef_tap_six_out,
  output wire signed [11:0] coef_tap_seven_out,
  output wire signed [11:0] coef_tap_eight_out
);

  localparam SEL_NONE = 3'd0;
  localparam SEL_CENTER = 3'd1;
  localparam SEL_SIX = 3'd2;
  localparam SEL_SEVEN = 3'd3;
  localparam SEL_EIGHT = 3'd4;
  localparam SIDE_TAPS = 3;
  localparam PAD_W = `CENTER_REG_W - `SIDE_REG_W;
  localparam [4:0] CENTER_MSB = `CENTER_FIELD_MSB;
  localparam [4:0] SIDE_MSB = `SIDE_FIELD_MSB;

  // Stored coefficients, reserved bits included
  reg [`CENTER_REG_W-1:0] coef_center_tap_chan_a;
  reg [`SIDE_REG_W-1:0] coef_tap_six_chan_a;
  reg [`SIDE_REG_W-1:0] coef_tap_seven_chan_a;
  reg [`SIDE_REG_W-1:0] coef_tap_eight_chan_a;
  reg setup_seen;

  // Next values
  reg next_setup_seen;
  reg [31:0] next_rdata;
  reg [31:0] next_prdata;
  reg next_pslverr;
  reg [`CENTER_REG_W-1:0] next_coef_center_tap_chan_a;
  reg [`SIDE_REG_W-1:0] next_coef_tap_six_chan_a;
  reg [`SIDE_REG_W-1:0] next_coef_tap_seven_chan_a;
  reg [`SIDE_REG_W-1:0] next_coef_tap_eight_chan_a;

  // Side taps packed six, seven, eight upward so one generate slice serves each
  wire [SIDE_TAPS*`SIDE_REG_W-1:0] side_regs;
  wire [SIDE_TAPS*`SIDE_REG_W-1:0] side_next;
  wire [SIDE_TAPS*32-1:0] side_views;
  wire [SIDE_TAPS-1:0] side_wr;

  // Word-aligned decode; byte lane bits must be zero
  // Indices are 13 bits; an ADDR_W below 13 leaves every tap index undecodable, as idx is zero-extended
  function [2:0] decode;
    input [ADDR_W-1:0] addr;
    reg [ADDR_W-3:0] idx;
    begin
      idx = addr[ADDR_W-1:2];
      if (addr[1:0] != 2'b00) begin
        decode = SEL_NONE;
      end else if (idx == `IDX_COEF_CENTER_TAP_CHAN_A) begin // R08
        decode = SEL_CENTER;
      end else if (idx == `IDX_COEF_TAP_SIX_CHAN_A) begin
        decode = SEL_SIX;
      end else if (idx == `IDX_COEF_TAP_SEVEN_CHAN_A) begin
        decode = SEL_SEVEN;
      end else if (idx == `IDX_COEF_TAP_EIGHT_CHAN_A) begin
        decode = SEL_EIGHT;
      end else begin
        decode = SEL_NONE;
      end
    end
  endfunction

  // Readback copy with the field's top bit cleared; the filter keeps the stored value
  function [31:0] read_view;
    input [`CENTER_REG_W-1:0] value;
    input [4:0] field_msb;
    reg [31:0] view;
    begin
      view = 32'h00000000;
      view[`CENTER_REG_W-1:0] = value;
      view[field_msb] = 1'b0; // R06
      read_view = view;
    end
  endfunction

  // While clock enable is low nothing advances and pready stays low, so a
  // master cannot finish a transfer that this block has not yet registered
  wire setup_phase = psel_in & ~penable_in & clk_en_in;
  wire access_phase = psel_in & penable_in;
  // Ready only once the read data was captured in a live setup cycle
  assign pready_out = setup_seen & clk_en_in;
  wire access_done = access_phase & pready_out;
  wire [2:0] sel = decode(paddr_in);
  wire sel_unmapped = (sel == SEL_NONE);
  wire wr_strobe = access_done & pwrite_in;
  wire wr_center = wr_strobe & (sel == SEL_CENTER);

  assign side_regs = {coef_tap_eight_chan_a, coef_tap_seven_chan_a, coef_tap_six_chan_a};
  assign side_wr[0] = wr_strobe & (sel == SEL_SIX);
  assign side_wr[1] = wr_strobe & (sel == SEL_SEVEN);
  assign side_wr[2] = wr_strobe & (sel == SEL_EIGHT);

  // The three side taps share one layout, so each gets the same write and read slice
  genvar t;
  generate
    for (t = 0; t < SIDE_TAPS; t = t + 1) begin : side_tap
      assign side_next[t*`SIDE_REG_W +: `SIDE_REG_W] = side_wr[t] ?
        pwdata_in[`SIDE_REG_W-1:0] : side_regs[t*`SIDE_REG_W +: `SIDE_REG_W];
      assign side_views[t*32 +: 32] =
        read_view({{PAD_W{1'b0}}, side_regs[t*`SIDE_REG_W +: `SIDE_REG_W]}, SIDE_MSB);
    end
  endgenerate

  // Reserved bits read as stored; only the field MSB is hidden
  always @* begin
    next_rdata = 32'h00000000;
    case (sel)
      SEL_CENTER: begin
        next_rdata = read_view(coef_center_tap_chan_a, CENTER_MSB); // R06
      end
      SEL_SIX: begin
        next_rdata = side_views[31:0]; // R06
      end
      SEL_SEVEN: begin
        next_rdata = side_views[63:32]; // R06
      end
      SEL_EIGHT: begin
        next_rdata = side_views[95:64]; // R06
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // Bus state: the setup edge captures the answer, the completing edge clears it
  always @* begin
    next_setup_seen = setup_seen;
    next_prdata = prdata_out;
    next_pslverr = pslverr_out;
    if (setup_phase) begin
      next_setup_seen = 1'b1;
      next_prdata = pwrite_in ? 32'h00000000 : next_rdata;
      next_pslverr = sel_unmapped;
    end else if (access_done) begin
      next_setup_seen = 1'b0;
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
    end
  end

  // Registered so read data and error stand through the whole access phase
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      setup_seen <= 1'b0;
      prdata_out <= 32'h00000000;
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      setup_seen <= next_setup_seen;
      prdata_out <= next_prdata;
      pslverr_out <= next_pslverr;
    end
  end

  // Writes land at the completing access edge; reserved bits are stored as written
  always @* begin
    next_coef_center_tap_chan_a = coef_center_tap_chan_a;
    if (wr_center) begin
      next_coef_center_tap_chan_a = pwdata_in[`CENTER_REG_W-1:0];
    end
  end

  always @* begin
    next_coef_tap_six_chan_a = side_next[0 +: `SIDE_REG_W];
    next_coef_tap_seven_chan_a = side_next[`SIDE_REG_W +: `SIDE_REG_W];
    next_coef_tap_eight_chan_a = side_next[2*`SIDE_REG_W +: `SIDE_REG_W];
  end

  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      coef_center_tap_chan_a <= `RST_COEF_CENTER_TAP_CHAN_A; // R08
      coef_tap_six_chan_a <= `RST_COEF_TAP_SIDE_CHAN_A;
      coef_tap_seven_chan_a <= `RST_COEF_TAP_SIDE_CHAN_A;
      coef_tap_eight_chan_a <= `RST_COEF_TAP_SIDE_CHAN_A;
    end else if (clk_en_in) begin
      coef_center_tap_chan_a <= next_coef_center_tap_chan_a;
      coef_tap_six_chan_a <= next_coef_tap_six_chan_a;
      coef_tap_seven_chan_a <= next_coef_tap_seven_chan_a;
      coef_tap_eight_chan_a <= next_coef_tap_eight_chan_a;
    end
  end

  // Same taps serve channel A in dual mode and the single filter otherwise
  // Tap five keeps its top field bit for the filter even though readback hides it
  assign coef_tap_five_out = $signed(coef_center_tap_chan_a[`CENTER_FIELD_MSB:0]); // R01 R02 R07
  assign coef_tap_six_out = $signed(coef_tap_six_chan_a[`SIDE_FIELD_MSB:0]); // R03 R07
  assign coef_tap_seven_out = $signed(coef_tap_seven_chan_a[`SIDE_FIELD_MSB:0]); // R04 R07
  assign coef_tap_eight_out = $signed(coef_tap_eight_chan_a[`SIDE_FIELD_MSB:0]); // R05 R07

endmodule

// *** fir_tap_coeff_bank_a_upper_chk.sv ***
`timescale 1ns/1ps
module fir_tap_coeff_bank_a_upper_chk #(parameter ADDR_W = 15) (
  input wire sys_clk_in, rst_in, clk_en_in, psel_in, penable_in, pwrite_in, pready_out,
  input wire pslverr_out,
  input wire [ADDR_W-1:0] paddr_in,
  input wire [31:0] pwdata_in, prdata_out,
  input wire signed [17:0] coef_tap_five_out,
  input wire signed [11:0] coef_tap_six_out, coef_tap_seven_out, coef_tap_eight_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  wire wr = psel_in & penable_in & pready_out & pwrite_in;
  wire rd = psel_in & penable_in & pready_out & !pwrite_in;
  wire [ADDR_W-1:0] a = paddr_in;
  wire [17:0] d_centre = pwdata_in[17:0];
  wire [11:0] d_side = pwdata_in[11:0];
  wire d_sign = pwdata_in[11];
  centre_write_a: assert property (wr && a == 'h1080 |=> coef_tap_five_out == $past(d_centre))
    else $error("tap five");
  six_write_a: assert property (wr && a == 'h108c |=> coef_tap_six_out == $past(d_side))
    else $error("tap six");
  seven_write_a: assert property (wr && a == 'h1094 |=> coef_tap_seven_out == $past(d_side))
    else $error("tap seven");
  eight_write_a: assert property (wr && a == 'h109c |=> coef_tap_eight_out == $past(d_side))
    else $error("tap eight");
  read_msb_a: assert property (rd && !pslverr_out |-> !prdata_out[a == 'h1080 ? 17 : 11])
    else $error("msb");
  centre_read_a: assert property (rd && a == 'h1080 |-> prdata_out[16:0] == coef_tap_five_out[16:0])
    else $error("readback");
  six_sign_a: assert property (wr && a == 'h108c |=> (coef_tap_six_out < 0) == $past(d_sign))
    else $error("sign");
  reset_zero_a: assert property ($fell(rst_in) |-> coef_tap_five_out == 0 && coef_tap_eight_out == 0)
    else $error("reset");
  centre_hold_a: assert property (!wr |=> $stable(coef_tap_five_out))
    else $error("hold");
  cover property (wr);
  cover property (rd);
  freeze_hold_a: assert property (!clk_en_in |=> $stable(coef_tap_six_out))
    else $error("freeze");
  cover property (rd && pslverr_out);
  cover property (psel_in && penable_in && !pready_out);
endmodule
bind fir_tap_coeff_bank_a_upper fir_tap_coeff_bank_a_upper_chk #(.ADDR_W(ADDR_W)) chk (.*);

// *** fir_tap_coeff_bank_a_upper_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module fir_tap_coeff_bank_a_upper_tb;
  reg sys_clk_in = 0, rst_in = 1, ps = 0, pe = 0, pw = 0, se, en = 1;
  reg [14:0] pa = 0;
  reg [31:0] wd = 0, rd;
  wire [31:0] prd;
  wire rdy, err;
  wire signed [17:0] t5;
  wire signed [11:0] t6, t7, t8;
  int miscompares = 0, n_tests = 0, cyc = 0;
  logic [14:0] ad [4] = '{15'h1080, 15'h108c, 15'h1094, 15'h109c};
  fir_tap_coeff_bank_a_upper uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en),
    .psel_in(ps), .penable_in(pe), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(wd),
    .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .coef_tap_five_out(t5),
    .coef_tap_six_out(t6), .coef_tap_seven_out(t7), .coef_tap_eight_out(t8));
  initial forever #10 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (++cyc == 2000) begin miscompares++; results; end
  // Idle edge first so psel is never assigned twice in one step
  task apb(input w, input [14:0] a, input [31:0] d);
    @(posedge sys_clk_in);
    ps <= 1; pw <= w; pa <= a; wd <= d;
    @(posedge sys_clk_in);
    pe <= 1;
    do @(posedge sys_clk_in); while (rdy !== 1'b1);
    rd = prd;
    se = err;
    ps <= 0; pe <= 0;
  endtask
  task reset_values;
    for (int i = 0; i < 4; i++) begin apb(0, ad[i], 0); `CHK(rd, 32'h0) end
  endtask
  task write_read;
    apb(1, ad[0], 32'h0002a5a5);
    for (int i = 1; i < 4; i++) apb(1, ad[i], 32'h900 + i);
    @(negedge sys_clk_in);
    `CHK(t5, 18'h2a5a5)
    `CHK(t5 < 0, 1'b1)
    `CHK(t6, 12'h901)
    `CHK(t7, 12'h902)
    `CHK(t8, 12'h903)
    apb(0, ad[0], 0); `CHK(rd, 32'ha5a5)
    for (int i = 1; i < 4; i++) begin apb(0, ad[i], 0); `CHK(rd, 32'h100 + i) end
  endtask
  task unmapped;
    apb(1, 15'h1084, 32'h123); `CHK(se, 1'b1)
    apb(0, 15'h1081, 0); `CHK({se, rd}, 33'h100000000)
  endtask
  task mid_reset;
    @(posedge sys_clk_in);
    rst_in <= 1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 0;
    @(negedge sys_clk_in);
    `CHK({t5, t6, t7, t8}, 54'h0)
    apb(0, ad[0], 0); `CHK(rd, 32'h0)
  endtask
  // Enable drops in the access phase: no ready, no write until it returns
  task stall;
    @(posedge sys_clk_in);
    ps <= 1; pw <= 1; pa <= ad[1]; wd <= 32'h00000321;
    @(posedge sys_clk_in);
    pe <= 1; en <= 0;
    repeat (2) @(posedge sys_clk_in);
    `CHK({rdy, t6}, 13'h0000)
    en <= 1;
    do @(posedge sys_clk_in); while (rdy !== 1'b1);
    ps <= 0; pe <= 0;
    @(negedge sys_clk_in);
    `CHK(t6, 12'h321)
  endtask
  task results;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_in <= 0;
    reset_values;
    write_read;
    unmapped;
    mid_reset;
    stall;
    results;
  end
endmodule
